// File: bench/pmrc_power_mode_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module pmrc_power_mode_checker
   import pmrc_pkg::*;
(
   // clock and reset
   input wire logic       core_clk,
   input wire logic       reset_n,
   // levels
   input wire logic       battery_supply_ok,
   input wire logic       battery_supply_full,
   input wire logic       logic_supply_ok,
   input wire logic       fail_safe_input_pin,
   input wire logic       in_pin_a,
   // outputs
   input wire logic       spi_so,
   input wire logic [7:0] channel_on,
   input wire logic       open_load_enable,
   input wire logic [1:0] mode_code,
   input wire logic       limp_home_active,
   input wire logic       transmission_error_flag
);
   // ****
   // mode checks
   // ****
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   // pin held past both sync stages
   sequence s_fs_held;
      (fail_safe_input_pin && battery_supply_ok && mode_code != 2'h0) [*4];
   endsequence
   sequence s_pin_a_held;
      (limp_home_active && in_pin_a) [*6];
   endsequence

   AST_RESET_STATE: assert property (disable iff (1'b0)
      !reset_n |=> channel_on == 8'h00 && mode_code == 2'h0 && transmission_error_flag)
      else $error("reset state wrong");
   AST_UV_OFF: assert property (
      mode_code == 2'h0 |-> channel_on == 8'h00 && transmission_error_flag)
      else $error("undervoltage state wrong");
   AST_SLEEP_OFF: assert property (mode_code == 2'h1 |-> channel_on == 8'h00)
      else $error("channel on in sleep");
   AST_LIMP_STATE: assert property (
      limp_home_active |-> mode_code == 2'h3 && (channel_on & 8'hE7) == 8'h00)
      else $error("limp state wrong");
   AST_LIMP_ENTRY: assert property (s_fs_held |-> ##[0:2] limp_home_active)
      else $error("limp not entered");
   AST_LIMP_EXIT: assert property (
      $fell(limp_home_active) |-> mode_code inside {2'h0, 2'h1})
      else $error("limp exit not to sleep");
   AST_LIMP_PIN: assert property (s_pin_a_held |-> channel_on[PMRC_LIMP_CH_A])
      else $error("pin a not routed");
   AST_RESTRICTED: assert property ((!battery_supply_full) [*4] |-> !open_load_enable)
      else $error("open load on in restricted band");
   AST_SO_IDLE: assert property ((!logic_supply_ok) [*4] |-> !spi_so)
      else $error("serial out active without logic supply");
   AST_UV_FIRST: assert property (
      (!battery_supply_ok) [*4] |-> mode_code == 2'h0 && !limp_home_active)
      else $error("undervoltage not taking priority");
   AST_VDD_HOLD: assert property (
      (!logic_supply_ok && battery_supply_ok && !fail_safe_input_pin) [*4] |=> $stable(channel_on))
      else $error("channels changed without logic supply");
endmodule

bind pmrc_power_mode pmrc_power_mode_checker u_chk (
   .core_clk(core_clk), .reset_n(reset_n), .battery_supply_ok(battery_supply_ok),
   .battery_supply_full(battery_supply_full), .logic_supply_ok(logic_supply_ok),
   .fail_safe_input_pin(fail_safe_input_pin), .in_pin_a(in_pin_a), .spi_so(spi_so),
   .channel_on(channel_on), .open_load_enable(open_load_enable), .mode_code(mode_code),
   .limp_home_active(limp_home_active), .transmission_error_flag(transmission_error_flag)
);

`default_nettype wire

// File: bench/pmrc_power_mode_bench.sv
`timescale 1ns/1ps
`default_nettype none

module pmrc_power_mode_bench
   import pmrc_pkg::*;
();
   // ****
   // signals
   // ****
   logic        core_clk;
   logic        reset_n;
   logic        battery_supply_ok;
   logic        battery_supply_full;
   logic        logic_supply_ok;
   logic        fail_safe_input_pin;
   logic        in_pin_a;
   logic        in_pin_b;
   logic [7:0]  open_load_sense;
   logic        spi_sclk;
   logic        spi_cs_n;
   logic        spi_si;
   logic        spi_so;
   logic [7:0]  channel_on;
   logic        open_load_enable;
   logic [1:0]  mode_code;
   logic        limp_home_active;
   logic        transmission_error_flag;
   logic [15:0] reply;
   int          bad_count = 0;
   int          n_tests = 0;
   int          cycles = 0;

   pmrc_power_mode DUT (
      .core_clk(core_clk), .reset_n(reset_n), .battery_supply_ok(battery_supply_ok),
      .battery_supply_full(battery_supply_full), .logic_supply_ok(logic_supply_ok),
      .fail_safe_input_pin(fail_safe_input_pin), .in_pin_a(in_pin_a), .in_pin_b(in_pin_b),
      .open_load_sense(open_load_sense), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_si(spi_si), .spi_so(spi_so), .channel_on(channel_on),
      .open_load_enable(open_load_enable), .mode_code(mode_code),
      .limp_home_active(limp_home_active), .transmission_error_flag(transmission_error_flag)
   );
   pmrc_spi_host host (
      .core_clk(core_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_si(spi_si), .spi_so(spi_so)
   );

   // ****
   // helpers
   // ****
   always #10 core_clk = ~core_clk;

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         end_of_test();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // opcode in top two bits: 0 read, 4xxx write, 8xxx command
   task automatic send(input logic [15:0] tx, input int nbits = 16);
      host.xfer(tx, nbits, reply);
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic wait_mode(input logic [1:0] m);
      for (int i = 0; i < 40 && mode_code !== m; i++) begin
         @(posedge core_clk);
         #1;
      end
      check({14'h0000, mode_code}, {14'h0000, m});
   endtask

   // ****
   // tests
   // ****
   initial begin
      core_clk = 1'b0;
      reset_n = 1'b0;
      battery_supply_ok = 1'b1;
      battery_supply_full = 1'b1;
      logic_supply_ok = 1'b1;
      fail_safe_input_pin = 1'b0;
      in_pin_a = 1'b0;
      in_pin_b = 1'b0;
      open_load_sense = 8'h00;
      step(12);
      reset_n = 1'b1;
      wait_mode(PMRC_SLEEP);
      send(16'h0000);
      check(reply, 16'h9000);
      check({15'h0000, transmission_error_flag}, 16'h0000);
      $display("test startup done");
      send(16'h8001);
      wait_mode(PMRC_OPERATE);
      send(16'h40A5);
      send(16'h405A, 15);
      send(16'h405A, 17);
      check(reply, 16'h4000);
      check({8'h00, channel_on}, 16'h00A5);
      send(16'h8004);
      check({6'h00, mode_code, channel_on}, 16'h0200);
      check({15'h0000, transmission_error_flag}, 16'h0001);
      $display("test operate done");
      send(16'h40FF);
      open_load_sense = 8'h21;
      step(6);
      check({15'h0000, open_load_enable}, 16'h0001);
      send(16'h0000);
      check(reply, 16'hA021);
      open_load_sense = 8'h00;
      send(16'h8004);
      send(16'h40FF);
      battery_supply_full = 1'b0;
      step(6);
      check({15'h0000, open_load_enable}, 16'h0000);
      send(16'h0000);
      check(reply, 16'hA800);
      check({8'h00, channel_on}, 16'h00FF);
      logic_supply_ok = 1'b0;
      step(10);
      check({7'h00, spi_so, channel_on}, 16'h00FF);
      logic_supply_ok = 1'b1;
      battery_supply_full = 1'b1;
      step(6);
      $display("test supply done");
      send(16'h8002);
      wait_mode(PMRC_SLEEP);
      send(16'h40FF);
      check({8'h00, channel_on}, 16'h0000);
      $display("test standby done");
      in_pin_a = 1'b1;
      fail_safe_input_pin = 1'b1;
      wait_mode(PMRC_LIMP);
      step(8);
      check({7'h00, limp_home_active, channel_on}, 16'h0108);
      send(16'h8001);
      send(16'h40FF);
      send(16'h0000);
      check(reply, 16'hF000);
      check({6'h00, mode_code, channel_on}, 16'h0308);
      logic_supply_ok = 1'b0;
      in_pin_a = 1'b0;
      in_pin_b = 1'b1;
      step(8);
      check({7'h00, limp_home_active, channel_on}, 16'h0110);
      logic_supply_ok = 1'b1;
      fail_safe_input_pin = 1'b0;
      wait_mode(PMRC_SLEEP);
      check({7'h00, limp_home_active, channel_on}, 16'h0000);
      $display("test limp done");
      send(16'h8001);
      wait_mode(PMRC_OPERATE);
      send(16'h403C);
      battery_supply_ok = 1'b0;
      battery_supply_full = 1'b0;
      wait_mode(PMRC_UV_RESET);
      check({7'h00, transmission_error_flag, channel_on}, 16'h0100);
      send(16'h0000);
      check(reply, 16'h8800);
      battery_supply_ok = 1'b1;
      logic_supply_ok = 1'b0;
      step(10);
      check({6'h00, mode_code, 7'h00, transmission_error_flag}, 16'h0001);
      logic_supply_ok = 1'b1;
      battery_supply_full = 1'b1;
      wait_mode(PMRC_SLEEP);
      $display("test undervoltage done");
      send(16'h8001);
      send(16'h4081);
      reset_n = 1'b0;
      step(12);
      check({7'h00, transmission_error_flag, channel_on}, 16'h0100);
      reset_n = 1'b1;
      wait_mode(PMRC_SLEEP);
      $display("test reset done");
      end_of_test();
   end
endmodule

`default_nettype wire

// File: bench/pmrc_spi_host.sv
`timescale 1ns/1ps
`default_nettype none

module pmrc_spi_host (
   // clock
   input  wire logic core_clk,
   // serial lines
   output logic      spi_sclk,
   output logic      spi_cs_n,
   output logic      spi_si,
   input  wire logic spi_so
);
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_si   = 1'b0;
   end

   // ****
   // one frame, mode 0, msb first
   // ****
   task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
      logic [31:0] sh;
      sh = {tx, 16'h0000};
      rx = 16'h0000;
      @(posedge core_clk);
      #1;
      spi_cs_n = 1'b0;
      #160;
      for (int i = 0; i < nbits; i++) begin
         spi_si = sh[31];
         sh     = {sh[30:0], 1'b0};
         #80;
         rx       = {rx[14:0], spi_so};
         spi_sclk = 1'b1;
         #80;
         spi_sclk = 1'b0;
      end
      #80;
      spi_cs_n = 1'b1;
      // released line must not keep last bit
      spi_si = ~spi_si;
      #200;
   endtask
endmodule

`default_nettype wire

// File: hw/pmrc_pkg.sv
package pmrc_pkg;

   // ***********************************************************
   // operating modes
   // ***********************************************************
   typedef enum logic [1:0] {
      PMRC_UV_RESET,
      PMRC_SLEEP,
      PMRC_OPERATE,
      PMRC_LIMP
   } pmrc_mode_type;

   // ***********************************************************
   // serial frame layout
   // ***********************************************************
   localparam int           PMRC_FRAME_BITS = 16;
   localparam int           PMRC_OP_HI      = 15;
   localparam int           PMRC_OP_LO      = 14;
   localparam logic [1:0]   PMRC_OP_READ    = 2'h0;
   localparam logic [1:0]   PMRC_OP_WRITE   = 2'h1;
   localparam logic [1:0]   PMRC_OP_COMMAND = 2'h2;
   // command field positions within a command frame
   localparam int           PMRC_CMD_WAKE   = 0;
   localparam int           PMRC_STANDBY_COMMAND_BIT    = 1;
   localparam int           PMRC_CMD_RST    = 2;

   // ***********************************************************
   // diagnostic frame layout
   // ***********************************************************
   localparam int           PMRC_DIAG_TER     = 15;
   localparam int           PMRC_DIAG_LIMP    = 14;
   localparam int           PMRC_DIAG_MODE_HI = 13;
   localparam int           PMRC_DIAG_MODE_LO = 12;
   localparam int           PMRC_DIAG_RESTR   = 11;

   // ***********************************************************
   // channels and reset values
   // ***********************************************************
   localparam int           PMRC_CHANNELS     = 8;
   localparam int           PMRC_LIMP_CH_A    = 3;
   localparam int           PMRC_LIMP_CH_B    = 4;
   localparam logic [7:0]   PMRC_CHANNEL_RST  = 8'h00;
   localparam logic [7:0]   PMRC_DIAG_RST     = 8'h00;
   localparam logic [15:0]  PMRC_SHIFT_RST    = 16'h0000;
   localparam logic [4:0]   PMRC_COUNT_RST    = 5'h00;
   localparam logic [4:0]   PMRC_COUNT_FULL   = 5'h10;

endpackage

// File: hw/pmrc_power_mode.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - battery startup: defaults, then sleep
// - wake command moves sleep to operation
// - standby command returns operation to sleep
// - entering sleep clears register banks
// - cranking above reset keeps switches, configuration
// - logic supply lost: channel outputs hold state, serial out forced low
// - shift path works whenever logic supply good
// - fail-safe high: limp, reset, pins drive
// - limp independent of logic supply
// - fail-safe high wakes from standby
// - limp end enters sleep, or reset if battery undervoltage at the same time
// - any reset: channels off, defaults
// - every reset sets transmission error flag
// - undervoltage reads give diagnostic with flag
// - release reset when both supplies good
// - reset command clears banks and diagnosis
// - limp: reads work, commands rejected
// - restricted band disables open-load detection
module pmrc_power_mode
   import pmrc_pkg::*;
(
   // clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     reset_n,
   // supply comparators and fail-safe pin
   input  wire logic                     battery_supply_ok,
   input  wire logic                     battery_supply_full,
   input  wire logic                     logic_supply_ok,
   input  wire logic                     fail_safe_input_pin,
   // direct input pins and open-load sense
   input  wire logic                     in_pin_a,
   input  wire logic                     in_pin_b,
   input  wire logic [PMRC_CHANNELS-1:0] open_load_sense,
   // serial port
   input  wire logic                     spi_sclk,
   input  wire logic                     spi_cs_n,
   input  wire logic                     spi_si,
   output logic                          spi_so,
   // power stages
   output logic      [PMRC_CHANNELS-1:0] channel_on,
   output logic                          open_load_enable,
   // status
   output logic      [1:0]               mode_code,
   output logic                          limp_home_active,
   output logic                          transmission_error_flag
);

   // ***********************************************************
   // input synchronisers
   // ***********************************************************
   localparam int SYNC_W = 9 + PMRC_CHANNELS;

   logic [SYNC_W-1:0]        sync_bus;
   logic                     batt_ok;
   logic                     batt_full;
   logic                     vdd_ok;
   logic                     fail_safe;
   logic                     pin_a;
   logic                     pin_b;
   logic                     sclk_s;
   logic                     cs_n_s;
   logic                     cs_sel_s;
   logic                     si_s;
   logic [PMRC_CHANNELS-1:0] ol_sense;

   pmrc_sync #(
      .WIDTH    (SYNC_W)
   ) u_sync (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .async_in ({battery_supply_ok, battery_supply_full, logic_supply_ok,
                  fail_safe_input_pin, in_pin_a, in_pin_b, spi_sclk, ~spi_cs_n,
                  spi_si, open_load_sense}),
      .sync_out (sync_bus)
   );

   assign {batt_ok, batt_full, vdd_ok, fail_safe, pin_a, pin_b,
           sclk_s, cs_sel_s, si_s} = sync_bus[SYNC_W-1:PMRC_CHANNELS];
   // select synced active high: reset value equals idle, no false edge
   assign cs_n_s = ~cs_sel_s;
   assign ol_sense = sync_bus[PMRC_CHANNELS-1:0];

   // ***********************************************************
   // helpers
   // ***********************************************************
   function automatic logic [1:0] encode_mode(input pmrc_mode_type m);
      logic [1:0] code;
      code = 2'h0;
      unique case (m)
         PMRC_UV_RESET: code = 2'h0;
         PMRC_SLEEP:    code = 2'h1;
         PMRC_OPERATE:  code = 2'h2;
         PMRC_LIMP:     code = 2'h3;
      endcase
      return code;
   endfunction

   function automatic logic is_op(input logic [15:0] frame, input logic [1:0] op);
      return frame[PMRC_OP_HI:PMRC_OP_LO] == op;
   endfunction

   // ***********************************************************
   // serial shift path
   // ***********************************************************
   logic                      sclk_prev;
   logic                      cs_n_prev;
   logic [PMRC_FRAME_BITS-1:0] shift_reg;
   logic [4:0]                bit_count;
   logic                      frame_done;
   logic [PMRC_FRAME_BITS-1:0] frame_data;
   logic [PMRC_FRAME_BITS-1:0] diag_frame;
   logic [PMRC_CHANNELS-1:0]  diag_flags;
   pmrc_mode_type             mode;

   assign diag_frame = {transmission_error_flag, limp_home_active, encode_mode(mode),
                        ~batt_full, 3'h0, diag_flags};

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         sclk_prev <= 1'b0;
         cs_n_prev <= 1'b1;
      end else begin
         sclk_prev <= sclk_s;
         cs_n_prev <= cs_n_s;
      end
   end

   // shift path gated only by logic supply
   always_ff @(posedge core_clk) begin
      if (!reset_n || !vdd_ok) begin
         shift_reg  <= PMRC_SHIFT_RST;
         bit_count  <= PMRC_COUNT_RST;
         frame_done <= 1'b0;
         frame_data <= PMRC_SHIFT_RST;
         spi_so     <= 1'b0;
      end else begin
         frame_done <= 1'b0;
         if (cs_n_prev && !cs_n_s) begin
            // reply frame carries flag during reset
            shift_reg <= diag_frame;
            spi_so    <= diag_frame[PMRC_FRAME_BITS-1];
            bit_count <= PMRC_COUNT_RST;
         end else if (!cs_n_s && !sclk_prev && sclk_s) begin
            shift_reg <= {shift_reg[PMRC_FRAME_BITS-2:0], si_s};
            // saturate so overlong frames stay refused
            if (bit_count != 5'h1F) begin
               bit_count <= bit_count + 5'h01;
            end
         end else if (!cs_n_s && sclk_prev && !sclk_s) begin
            spi_so <= shift_reg[PMRC_FRAME_BITS-1];
         end else if (!cs_n_prev && cs_n_s) begin
            frame_done <= (bit_count == PMRC_COUNT_FULL);
            frame_data <= shift_reg;
         end
      end
   end

   // ***********************************************************
   // command decode
   // ***********************************************************
   logic cmd_frame;
   logic cmd_wake;
   logic cmd_standby;
   logic cmd_reset;
   logic write_frame;
   logic read_frame;

   // no command taken in limp or reset
   assign cmd_frame   = frame_done && !fail_safe &&
                        (mode == PMRC_SLEEP || mode == PMRC_OPERATE);
   assign cmd_wake    = cmd_frame && is_op(frame_data, PMRC_OP_COMMAND) &&
                        frame_data[PMRC_CMD_WAKE];
   assign cmd_standby = cmd_frame && is_op(frame_data, PMRC_OP_COMMAND) &&
                        frame_data[PMRC_STANDBY_COMMAND_BIT];
   assign cmd_reset   = cmd_frame && is_op(frame_data, PMRC_OP_COMMAND) &&
                        frame_data[PMRC_CMD_RST];
   assign write_frame = cmd_frame && mode == PMRC_OPERATE &&
                        is_op(frame_data, PMRC_OP_WRITE);
   assign read_frame  = frame_done && mode != PMRC_UV_RESET &&
                        is_op(frame_data, PMRC_OP_READ);

   // ***********************************************************
   // mode machine
   // ***********************************************************
   pmrc_mode_type next_mode;

   always_comb begin
      next_mode = mode;
      unique case (mode)
         PMRC_UV_RESET: if (batt_ok && vdd_ok) begin
            next_mode = PMRC_SLEEP;
         end
         PMRC_SLEEP: begin
            if (fail_safe) begin
               next_mode = PMRC_LIMP;
            end else if (cmd_wake) begin
               next_mode = PMRC_OPERATE;
            end
         end
         PMRC_OPERATE: begin
            if (fail_safe) begin
               next_mode = PMRC_LIMP;
            end else if (cmd_standby) begin
               next_mode = PMRC_SLEEP;
            end
         end
         PMRC_LIMP: begin
            if (!fail_safe) begin
               next_mode = PMRC_SLEEP;
            end
         end
      endcase
      if (!batt_ok) begin
         next_mode = PMRC_UV_RESET;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         mode <= PMRC_UV_RESET;
      end else begin
         mode <= next_mode;
      end
   end

   // ***********************************************************
   // register bank and diagnosis
   // ***********************************************************
   logic [PMRC_CHANNELS-1:0] channel_cfg;
   logic                     bank_clear;

   assign bank_clear = next_mode != PMRC_OPERATE || cmd_reset;

   always_ff @(posedge core_clk) begin
      if (!reset_n || bank_clear) begin
         channel_cfg <= PMRC_CHANNEL_RST;
      end else if (write_frame) begin
         channel_cfg <= frame_data[PMRC_CHANNELS-1:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n || mode == PMRC_UV_RESET || cmd_reset) begin
         diag_flags <= PMRC_DIAG_RST;
      end else if (open_load_enable) begin
         diag_flags <= diag_flags | (ol_sense & channel_cfg);
      end
   end

   // ***********************************************************
   // power stage drive
   // ***********************************************************
   // no logic supply term here
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         channel_on <= PMRC_CHANNEL_RST;
      end else begin
         channel_on <= PMRC_CHANNEL_RST;
         if (next_mode == PMRC_OPERATE && !cmd_reset) begin
            channel_on <= write_frame ? frame_data[PMRC_CHANNELS-1:0] : channel_cfg;
         end else if (next_mode == PMRC_LIMP) begin
            channel_on[PMRC_LIMP_CH_A] <= pin_a;
            channel_on[PMRC_LIMP_CH_B] <= pin_b;
         end
      end
   end

   // open-load only in full supply band
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         open_load_enable <= 1'b0;
      end else begin
         open_load_enable <= batt_ok && batt_full && next_mode == PMRC_OPERATE;
      end
   end

   // ***********************************************************
   // status
   // ***********************************************************
   logic reset_event;

   assign reset_event = next_mode == PMRC_UV_RESET || cmd_reset ||
                        (next_mode == PMRC_LIMP && mode != PMRC_LIMP);

   always_ff @(posedge core_clk) begin
      if (!reset_n || reset_event) begin
         transmission_error_flag <= 1'b1;
      end else if (read_frame) begin
         transmission_error_flag <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         mode_code        <= 2'h0;
         limp_home_active <= 1'b0;
      end else begin
         mode_code        <= encode_mode(next_mode);
         limp_home_active <= next_mode == PMRC_LIMP;
      end
   end

endmodule

`default_nettype wire

// File: hw/pmrc_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pmrc_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             reset_n,
   // levels
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage_one;

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         stage_one <= '0;
         sync_out  <= '0;
      end else begin
         stage_one <= async_in;
         sync_out  <= stage_one;
      end
   end

endmodule

`default_nettype wire
